// *** design/sit_pkg.sv ***
// Purpose: Shared constants and types for the sensor two-wire target port
// Assumes: System clock of 125 MHz (8 ns period)
// Notes:   Long cycle counts are defaults for top-level parameters
package sit_pkg;

	// ==========================================================
	// Target addresses
	localparam logic [6:0] SIT_ADDR_DEFAULT = 7'h44;   // Default address option
	localparam logic [6:0] SIT_ADDR_ALT     = 7'h45;   // Alternate address option
	localparam int         SIT_STRAP_BIT    = 1;       // Bit set when strap pin grounded

	// ==========================================================
	// Timing, in nanoseconds, and derived cycle counts
	localparam int SIT_CLK_NS         = 8;             // System clock period
	localparam int SIT_BUS_MAX_KHZ    = 400;           // Fastest bus clock served
	localparam int SIT_STRETCH_MIN_NS = 60000;         // Least in-window stretch
	localparam int SIT_STRETCH_MAX_NS = 128000;        // Longest in-window stretch
	localparam int SIT_POLL_NS        = 250000;        // Out-of-window poll interval
	localparam int SIT_POLL_MAX_NS    = 1000000;       // Bound on out-of-window stretch
	localparam int SIT_TMO_NS         = 10240000;      // Ready window idle timeout
	// Least time rounds up
	localparam int SIT_STRETCH_CYC = (SIT_STRETCH_MIN_NS + SIT_CLK_NS - 1) / SIT_CLK_NS;
	// Longest times round down
	localparam int SIT_POLL_CYC    = SIT_POLL_NS / SIT_CLK_NS;
	localparam int SIT_TMO_CYC     = SIT_TMO_NS / SIT_CLK_NS;
	localparam int SIT_CNT_W       = 21;               // Width of cycle counters

	// ==========================================================
	// Frame fields
	localparam int SIT_BITS_PER_BYTE = 8;              // Bits before acknowledge slot

	// ==========================================================
	// Register pair write carried to the application
	typedef struct packed {
		logic [7:0]  cmd;                              // Address-command of the pair
		logic [15:0] data;                             // Offset 1 high, offset 0 low
	} sit_wr_type;

endpackage

// *** design/sit_i2c_target.sv ***
// Purpose: Two-wire target port with open-drain ready line and window control
// Assumes: SCL/SDA/strap arrive asynchronously; bus clock no faster than 400 kHz
// Notes:   Register data lives outside; rd_data must follow reg_sel combinationally
`timescale 1ns/1ps

module sit_i2c_target
	import sit_pkg::*;
#(
	parameter int STRETCH_CYC = SIT_STRETCH_CYC,     // In-window load stretch
	parameter int POLL_CYC    = SIT_POLL_CYC,        // Out-of-window poll interval
	parameter int TMO_CYC     = SIT_TMO_CYC          // Ready window idle timeout
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Bus clock pin
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	// Bus data pin
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Ready pin, open drain
	output logic             rdy_out,
	output logic             rdy_oe,
	// Address configuration
	input  wire logic        address_strap_pin,
	input  wire logic        addr_alt_opt,
	input  wire logic        strap_enable,
	// Reporting control
	input  wire logic        event_mode,
	input  wire logic        report_sample,
	input  wire logic        report_event,
	input  wire logic        stop_ignore,
	// Register pair access
	output logic [7:0]       reg_sel,
	input  wire logic [15:0] rd_data,
	output logic             wr_valid,
	output sit_wr_type       wr_word,
	output logic             window_open
);

	// ==========================================================
	// Declarations
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_WAITWIN, ST_CMD, ST_CACK,
		ST_LOAD, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
	} sit_state_type;

	sit_state_type          state_reg;       // Frame state
	logic [2:0]             meta_reg;        // First synchroniser stage
	logic [2:0]             sync_reg;        // Second synchroniser stage
	logic                   scl_d_reg;       // Delayed bus clock
	logic                   sda_d_reg;       // Delayed bus data
	logic [7:0]             shift_reg;       // Received byte
	logic [7:0]             tx_reg;          // Byte being sent
	logic [3:0]             bit_cnt_reg;     // Bit position in byte
	logic                   rw_reg;          // Read requested
	logic                   byte_sel_reg;    // Next byte is offset 1
	logic                   ack_reg;         // Master acked last read byte
	logic [7:0]             cmd_reg;         // Current address-command
	logic [15:0]            word_reg;        // Pair being moved
	logic [SIT_CNT_W-1:0]   cnt_reg;         // Stretch and poll counter
	logic [SIT_CNT_W-1:0]   idle_cnt_reg;    // Window idle counter
	logic                   win_reg;         // Communication window open
	logic                   addressed_reg;   // Addressed in this window
	logic                   scl_oe_reg;      // Holding clock low
	logic                   sda_oe_reg;      // Pulling data low
	logic                   od_low_reg;      // Constant low level for drivers
	logic                   wr_valid_reg;    // Pair write pulse
	sit_wr_type             wr_reg;          // Pair write contents

	// ==========================================================
	// Edge and condition decode
	wire scl_s     = sync_reg[2];
	wire sda_s     = sync_reg[1];
	wire strap_s   = sync_reg[0];
	wire scl_rise  = scl_s & ~scl_d_reg;
	wire scl_fall  = ~scl_s & scl_d_reg;
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire byte_done = scl_fall & (bit_cnt_reg == 4'(SIT_BITS_PER_BYTE));
	wire bus_act   = scl_rise | scl_fall | start_det | stop_det;

	// Own address from option and strap
	wire [6:0] base_addr = addr_alt_opt ? SIT_ADDR_ALT : SIT_ADDR_DEFAULT;
	wire       strap_gnd = strap_enable & ~strap_s;
	wire [6:0] own_addr  = base_addr | (7'(strap_gnd) << SIT_STRAP_BIT);
	wire       addr_hit  = (shift_reg[7:1] == own_addr);

	// Next read byte: offset 0 fresh from the pair, offset 1 from the held word
	wire [7:0] rd_tx     = byte_sel_reg ? word_reg[15:8] : rd_data[7:0];

	// Window open and close requests
	wire open_req  = event_mode ? report_event : report_sample;
	wire poll_due  = (state_reg == ST_WAITWIN) &&
	                 (cnt_reg >= SIT_CNT_W'(POLL_CYC - 1));
	wire tmo_hit   = win_reg && (idle_cnt_reg >= SIT_CNT_W'(TMO_CYC - 1));
	wire stop_end  = stop_det & addressed_reg & ~stop_ignore;
	wire win_close = tmo_hit | stop_end;

	// ==========================================================
	// Synchronisers for pins; oversampling serves bus clocks up to 400 kHz
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg  <= 3'h7;
			sync_reg  <= 3'h7;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			meta_reg  <= {scl_in, sda_in, address_strap_pin};
			sync_reg  <= meta_reg;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// ==========================================================
	// Communication window and ready line
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			win_reg      <= 1'b0;
			idle_cnt_reg <= '0;
			od_low_reg   <= 1'b0;
		end else begin
			// A new report wins over a close in the same cycle
			if (open_req || poll_due) begin
				win_reg <= 1'b1;
			end else if (win_close) begin
				win_reg <= 1'b0;
			end
			// Idle time counted only while the window stands
			if (!win_reg || bus_act) begin
				idle_cnt_reg <= '0;
			end else if (!tmo_hit) begin
				idle_cnt_reg <= idle_cnt_reg + 1'b1;
			end
		end
	end

	// ==========================================================
	// Frame state machine
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg     <= ST_IDLE;
			shift_reg     <= 8'h00;
			tx_reg        <= 8'h00;
			bit_cnt_reg   <= 4'h0;
			rw_reg        <= 1'b0;
			byte_sel_reg  <= 1'b0;
			ack_reg       <= 1'b0;
			cmd_reg       <= 8'h00;
			word_reg      <= 16'h0000;
			cnt_reg       <= '0;
			addressed_reg <= 1'b0;
			scl_oe_reg    <= 1'b0;
			sda_oe_reg    <= 1'b0;
			wr_valid_reg  <= 1'b0;
			wr_reg        <= '0;
		end else begin
			wr_valid_reg <= 1'b0;
			if (win_close && !open_req) begin
				addressed_reg <= 1'b0;
			end
			if (start_det) begin
				// Start or repeated start restarts address phase
				state_reg   <= ST_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe_reg  <= 1'b0;
				scl_oe_reg  <= 1'b0;
			end else if (stop_det) begin
				state_reg  <= ST_IDLE;
				sda_oe_reg <= 1'b0;
				scl_oe_reg <= 1'b0;
			end else begin
				case (state_reg)
					ST_ADDR, ST_CMD, ST_WDATA: begin
						// Receive a byte, msb first, sampled on rising clock
						if (scl_rise) begin
							shift_reg   <= {shift_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (byte_done) begin
							sda_oe_reg <= 1'b1;
							if (state_reg == ST_ADDR) begin
								// Acknowledge only our own address
								if (addr_hit) begin
									rw_reg        <= shift_reg[0];
									byte_sel_reg  <= 1'b0;
									addressed_reg <= 1'b1;
									state_reg     <= ST_AACK;
								end else begin
									sda_oe_reg <= 1'b0;
									state_reg  <= ST_IDLE;
								end
							end else if (state_reg == ST_CMD) begin
								state_reg <= ST_CACK;
							end else begin
								// Offset 0 held, offset 1 completes the pair
								if (!byte_sel_reg) begin
									word_reg[7:0] <= shift_reg;
								end else begin
									wr_reg       <= '{cmd: cmd_reg,
									                  data: {shift_reg, word_reg[7:0]}};
									wr_valid_reg <= 1'b1;
									cmd_reg      <= cmd_reg + 8'h01;
								end
								byte_sel_reg <= ~byte_sel_reg;
								state_reg    <= ST_WACK;
							end
						end
					end
					ST_AACK, ST_WAITWIN: begin
						if (state_reg == ST_WAITWIN) begin
							cnt_reg <= cnt_reg + 1'b1;
						end
						if ((state_reg == ST_AACK && scl_fall && !win_reg)) begin
							// Hold the clock until a window is entered
							sda_oe_reg <= 1'b0;
							scl_oe_reg <= 1'b1;
							cnt_reg    <= '0;
							state_reg  <= ST_WAITWIN;
						end else if ((state_reg == ST_AACK && scl_fall) ||
						             (state_reg == ST_WAITWIN && win_reg)) begin
							scl_oe_reg  <= 1'b0;
							bit_cnt_reg <= 4'h0;
							if (rw_reg) begin
								// Current-address read starts at offset 0
								tx_reg       <= rd_tx;
								sda_oe_reg   <= ~rd_tx[7];
								word_reg     <= rd_data;
								byte_sel_reg <= 1'b1;
								state_reg    <= ST_RDATA;
							end else begin
								sda_oe_reg <= 1'b0;
								state_reg  <= ST_CMD;
							end
						end
					end
					ST_CACK: begin
						if (scl_fall) begin
							// New command: stretch while data is loaded
							sda_oe_reg   <= 1'b0;
							cmd_reg      <= shift_reg;
							byte_sel_reg <= 1'b0;
							scl_oe_reg   <= 1'b1;
							cnt_reg      <= '0;
							state_reg    <= ST_LOAD;
						end
					end
					ST_LOAD: begin
						cnt_reg <= cnt_reg + 1'b1;
						if (cnt_reg >= SIT_CNT_W'(STRETCH_CYC - 1)) begin
							scl_oe_reg  <= 1'b0;
							bit_cnt_reg <= 4'h0;
							state_reg   <= ST_WDATA;
						end
					end
					ST_WACK: begin
						if (scl_fall) begin
							sda_oe_reg  <= 1'b0;
							bit_cnt_reg <= 4'h0;
							state_reg   <= ST_WDATA;
						end
					end
					ST_RDATA: begin
						// Present next bit after each falling clock
						if (scl_fall) begin
							if (bit_cnt_reg == 4'(SIT_BITS_PER_BYTE - 1)) begin
								sda_oe_reg <= 1'b0;
								state_reg  <= ST_RACK;
							end else begin
								sda_oe_reg  <= ~tx_reg[6];
								tx_reg      <= {tx_reg[6:0], 1'b0};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							ack_reg <= ~sda_s;
							// Pair finished: step to next command early for rd_data
							if (!sda_s && !byte_sel_reg) begin
								cmd_reg <= cmd_reg + 8'h01;
							end
						end else if (scl_fall) begin
							bit_cnt_reg <= 4'h0;
							if (ack_reg) begin
								tx_reg       <= rd_tx;
								sda_oe_reg   <= ~rd_tx[7];
								byte_sel_reg <= ~byte_sel_reg;
								if (!byte_sel_reg) begin
									word_reg <= rd_data;
								end
								state_reg <= ST_RDATA;
							end else begin
								// Master nack ends reading; wait for stop
								state_reg <= ST_IDLE;
							end
						end
					end
					default: begin
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Outputs
	assign scl_out     = od_low_reg;
	assign scl_oe      = scl_oe_reg;
	assign sda_out     = od_low_reg;
	assign sda_oe      = sda_oe_reg;
	assign rdy_out     = od_low_reg;
	assign rdy_oe      = win_reg;
	assign reg_sel     = cmd_reg;
	assign wr_valid    = wr_valid_reg;
	assign wr_word     = wr_reg;
	assign window_open = win_reg;

	// ==========================================================
	// Checks
	a_stream_open: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!event_mode && report_sample) |=> rdy_oe)
		else $error("stream sample did not open window");
	a_event_open: assert property (@(posedge sys_clk) disable iff (!rstn)
		(event_mode && report_event && !report_sample) |=> rdy_oe)
		else $error("event did not open window");
	a_ack_stretch: assert property (@(posedge sys_clk) disable iff (!rstn)
		(state_reg == ST_AACK && scl_fall && !win_reg && !start_det && !stop_det)
		|=> scl_oe && !sda_oe)
		else $error("no stretch after out-of-window ack");
	a_poll_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
		(state_reg == ST_WAITWIN) |-> (cnt_reg <= SIT_CNT_W'(POLL_CYC)))
		else $error("out-of-window stretch too long");
	a_rdy_level: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(win_reg) |-> (rdy_oe && !rdy_out))
		else $error("ready line not pulled low in window");
	a_addr_ack: assert property (@(posedge sys_clk) disable iff (!rstn)
		(state_reg == ST_ADDR && byte_done && !start_det && !stop_det &&
		 shift_reg[7:1] == (addr_alt_opt ? 7'h45 : 7'h44) && !strap_enable)
		|=> (sda_oe && state_reg == ST_AACK))
		else $error("own address not acknowledged");
	a_strap_ack: assert property (@(posedge sys_clk) disable iff (!rstn)
		(state_reg == ST_ADDR && byte_done && !start_det && !stop_det &&
		 strap_enable && !strap_s && shift_reg[7:1] == (addr_alt_opt ? 7'h47 : 7'h46))
		|=> sda_oe)
		else $error("strapped address not acknowledged");
	a_stretch_len: assert property (@(posedge sys_clk) disable iff (!rstn)
		($fell(scl_oe) && $past(state_reg) == ST_LOAD && !$past(start_det) &&
		 !$past(stop_det)) |-> ($past(cnt_reg) == SIT_CNT_W'(STRETCH_CYC - 1)))
		else $error("load stretch length wrong");
	a_idle_close: assert property (@(posedge sys_clk) disable iff (!rstn)
		(tmo_hit && !open_req && !poll_due) |=> !window_open)
		else $error("idle window not closed");
	a_stop_close: assert property (@(posedge sys_clk) disable iff (!rstn)
		(stop_det && addressed_reg && !stop_ignore && !open_req && !poll_due)
		|=> !rdy_oe)
		else $error("stop did not close window");

endmodule

// *** verification/sit_host_model.sv ***
// Purpose: Host-side bus master model for the two-wire target port
// Assumes: Pull-ups on both lines; the target may stretch the clock
// Notes:   Tasks are called from the bench; drives are open-drain enables
`timescale 1ns/1ps
module sit_host_model (
	// Open-drain drives, high pulls the line low
	output logic      scl_oe,
	output logic      sda_oe,
	// Resolved line levels
	input  wire logic scl,
	input  wire logic sda
);
	// ==========================================================
	// Bus timing and stretch bookkeeping
	localparam time HALF = 80;     // Half of the 160 ns bus clock
	time            t_fall;        // When this master last pulled the clock low
	time            max_low;       // Longest clock low seen, stretch included

	// Lines released at time zero
	initial begin
		scl_oe  = 1'b0;
		sda_oe  = 1'b0;
		t_fall  = 0;
		max_low = 0;
	end

	// Release the clock; a stretching target keeps it low, so wait bounded
	task automatic rel_scl();
		int n;
		scl_oe = 1'b0;
		n = 0;
		while (scl !== 1'b1 && n < 20000) begin
			#8;
			n++;
		end
		if ($time - t_fall > max_low)
			max_low = $time - t_fall;
	endtask

	// Pull the clock low and note the moment
	task automatic low_scl();
		scl_oe = 1'b1;
		t_fall = $time;
	endtask

	// One bit slot: drive b while low, sample the line in mid-high
	task automatic xbit(input logic b, output logic r);
		#(HALF/2) sda_oe = ~b;
		#(HALF/2) rel_scl();
		#(HALF/2) r = sda;
		#(HALF/2) low_scl();
	endtask

	// Start or repeated start; waits so a target acknowledge clears first
	task automatic start();
		#HALF sda_oe = 1'b0;
		rel_scl();
		#HALF sda_oe = 1'b1;
		#HALF low_scl();
	endtask

	// Stop: data rises while the clock is high
	task automatic stop();
		#(HALF/2) sda_oe = 1'b1;
		#(HALF/2) rel_scl();
		#HALF sda_oe = 1'b0;
		#HALF;
	endtask

	// Send a byte MSB first, return the acknowledge level (0 = ack)
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(d[i], r);
		xbit(1'b1, ack);
	endtask

	// Receive a byte MSB first, then acknowledge or not
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(1'b1, d[i]);
		xbit(nack, r);
	endtask
endmodule

// *** verification/sit_i2c_target_tb.sv ***
// Purpose: Self-checking bench for the two-wire target port
// Assumes: Scaled stretch, poll and timeout counts
// Notes:   Pair writes are queued and matched when wr_valid appears
`timescale 1ns/1ps
module sit_i2c_target_tb;
	import sit_pkg::*;
	// ==========================================================
	// Scaled counts, cycles
	localparam int STR  = 20;   // Load stretch
	localparam int POLL = 50;   // Out-of-window poll
	localparam int TMO  = 400;  // Idle timeout
	// Design pins and bench state
	logic        sys_clk, rstn, address_strap_pin, addr_alt_opt, strap_enable;
	logic        event_mode, report_sample, report_event, stop_ignore;
	logic        scl_out, scl_oe, sda_out, sda_oe, rdy_out, rdy_oe, wr_valid, window_open;
	logic        h_scl_oe, h_sda_oe;
	logic [7:0]  reg_sel;
	sit_wr_type  wr_word;
	wire  logic  scl_w, sda_w, rdy_w;
	wire  logic [15:0] rd_data;
	logic [23:0] exp_q[$];      // Expected pair writes
	int          miscompares, tests_run;
	time         oow_low, cmd_low;

	// Wired-AND lines with pull-ups; pair data follows the selection
	assign scl_w   = (scl_oe ? scl_out : 1'b1) & ~h_scl_oe;
	assign sda_w   = (sda_oe ? sda_out : 1'b1) & ~h_sda_oe;
	assign rdy_w   = rdy_oe ? rdy_out : 1'b1;
	assign rd_data = {reg_sel ^ 8'hc3, reg_sel};

	// Clock
	always #4 sys_clk = ~sys_clk;

	sit_i2c_target #(.STRETCH_CYC(STR), .POLL_CYC(POLL), .TMO_CYC(TMO)) sit_i2c_target_i (
		.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .rdy_out(rdy_out), .rdy_oe(rdy_oe),
		.address_strap_pin(address_strap_pin), .addr_alt_opt(addr_alt_opt),
		.strap_enable(strap_enable), .event_mode(event_mode), .report_sample(report_sample),
		.report_event(report_event), .stop_ignore(stop_ignore), .reg_sel(reg_sel),
		.rd_data(rd_data), .wr_valid(wr_valid), .wr_word(wr_word), .window_open(window_open));

	sit_host_model host_i (.scl_oe(h_scl_oe), .sda_oe(h_sda_oe), .scl(scl_w), .sda(sda_w));

	// ==========================================================
	// Checking and closing
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic in_range(input time v, input time lo, input time hi);
		check({23'h0, (v >= lo && v <= hi)}, 24'h00_0001);
	endtask

	task automatic wrap_up();
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// One-cycle report pulse, event or sample
	task automatic pulse(input logic ev);
		@(negedge sys_clk);
		report_event  = ev;
		report_sample = ~ev;
		@(negedge sys_clk);
		report_event  = 1'b0;
		report_sample = 1'b0;
	endtask

	// Write n pairs from command c, plus an optional lone byte; then stop
	task automatic wr_pairs(input logic [7:0] c, input int n, input logic odd, input logic open);
		logic        ack;
		logic [15:0] d;
		host_i.start();
		host_i.max_low = 0;
		host_i.wbyte(8'h88, ack);
		check({23'h0, ack}, 24'h0);
		host_i.wbyte(c, ack);
		oow_low = host_i.max_low;
		host_i.max_low = 0;
		check({23'h0, ack}, 24'h0);
		for (int i = 0; i < n; i++) begin
			d = 16'($urandom);
			exp_q.push_back({c + 8'(i), d});
			host_i.wbyte(d[7:0], ack);
			if (i == 0)
				cmd_low = host_i.max_low;
			check({23'h0, ack}, 24'h0);
			host_i.wbyte(d[15:8], ack);
			check({23'h0, ack}, 24'h0);
		end
		if (odd)
			host_i.wbyte(8'h5a, ack);
		check({22'h0, window_open, rdy_w}, 24'h00_0002);
		host_i.stop();
		cyc(3);
		check({23'h0, window_open}, {23'h0, open});
	endtask

	// Read n pairs, random (command first) or current address
	task automatic rd_pairs(input logic [7:0] c, input int n, input logic rnd);
		logic       ack;
		logic [7:0] b0, b1;
		host_i.start();
		if (rnd) begin
			host_i.wbyte(8'h88, ack);
			host_i.wbyte(c, ack);
			host_i.start();
		end
		host_i.wbyte(8'h89, ack);
		check({23'h0, ack}, 24'h0);
		for (int i = 0; i < n; i++) begin
			host_i.rbyte(1'b0, b0);
			host_i.rbyte(i == n - 1, b1);
			check({8'h0, b1, b0}, {8'h0, (c + 8'(i)) ^ 8'hc3, c + 8'(i)});
		end
		host_i.stop();
	endtask

	// Pair write monitor: oldest note against each wr_valid
	always @(negedge sys_clk) begin
		if (wr_valid === 1'b1)
			check(wr_word, (exp_q.size() > 0) ? exp_q.pop_front() : 24'hx);
	end

	// Watchdog
	initial begin
		#500000;
		miscompares++;
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic       ack;
		logic [6:0] a;
		logic [7:0] c;
		{sys_clk, rstn, report_sample, report_event, event_mode, stop_ignore} = '0;
		{address_strap_pin, addr_alt_opt, strap_enable} = 3'b100;
		miscompares = 0;
		tests_run   = 0;
		void'($urandom(32'hdff8_1199));
		cyc(20);
		rstn = 1'b1;
		cyc(5);
		check({14'h0, window_open, rdy_w, reg_sel}, 24'h00_0100);
		// Address options: wrong address refused, right one acknowledged
		for (int i = 0; i < 5; i++) begin
			addr_alt_opt      = i[0];
			strap_enable      = (i < 4);
			address_strap_pin = (i == 4) ? 1'b0 : ~i[1];
			cyc(5);
			a = (addr_alt_opt ? 7'h45 : 7'h44) | ((strap_enable && !address_strap_pin) ? 7'h02 : 7'h00);
			host_i.start();
			host_i.wbyte({a ^ 7'h02, 1'b0}, ack);
			host_i.stop();
			check({23'h0, ack}, 24'h00_0001);
			host_i.start();
			host_i.wbyte({a, 1'b0}, ack);
			host_i.stop();
			check({23'h0, ack}, 24'h0);
			cyc(3);
			check({23'h0, window_open}, 24'h0);
		end
		{address_strap_pin, addr_alt_opt, strap_enable} = 3'b100;
		cyc(5);
		// Out-of-window write: poll opens the window, command stretch bounded
		c = 8'($urandom);
		wr_pairs(c, 2, 1'b0, 1'b0);
		in_range(oow_low, 0, POLL * 4 * 8);
		in_range(cmd_low, STR * 8, STR * 128 / 60 * 8);
		// Streaming: sample report opens, random read, stop closes
		pulse(1'b0);
		cyc(3);
		check({23'h0, window_open}, 24'h00_0001);
		c = 8'($urandom);
		rd_pairs(c, 1, 1'b1);
		cyc(3);
		check({23'h0, window_open}, 24'h0);
		// Event style: a sample does not open, an event does
		event_mode = 1'b1;
		pulse(1'b0);
		cyc(3);
		check({23'h0, window_open}, 24'h0);
		pulse(1'b1);
		cyc(3);
		check({23'h0, window_open}, 24'h00_0001);
		// A nacked last byte leaves the command where the random read set it
		rd_pairs(c, 2, 1'b0);
		// Stop ignored, lone byte held, then idle timeout closes the window
		stop_ignore = 1'b1;
		pulse(1'b1);
		wr_pairs(8'($urandom), 1, 1'b1, 1'b1);
		cyc(TMO - 30);
		check({23'h0, window_open}, 24'h00_0001);
		cyc(60);
		check({23'h0, window_open, 8'h0}, 24'h0);
		check(24'(exp_q.size()), 24'h0);
		wrap_up();
	end
endmodule
